// ==== logic/osccc_cfg.svh ====
// Register indices, field positions, reset values and masks of the oscillator clock control.
// Assumes it is included by the package, the top module and the bench of this block only.
`ifndef OSCCC_CFG_SVH
`define OSCCC_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define OSCCC_IDX_CLOCK_CONFIG    10'h0E2
`define OSCCC_IDX_MAIN_OSC_TRIM   10'h0E8
`define OSCCC_IDX_LOW_OSC_TRIM    10'h0E9
`define OSCCC_IDX_SYS_STATUS      10'h0FE
`define OSCCC_IDX_IRQ_STATUS      10'h0F0
`define OSCCC_IDX_IRQ_MASK        10'h0F1
`define OSCCC_IDX_AUX_CTRL        10'h0F2

// ==========================================================================
// Reset values
`define OSCCC_RST_CLOCK_CONFIG    8'h00
`define OSCCC_RST_MAIN_OSC_TRIM   8'h00
`define OSCCC_RST_LOW_OSC_TRIM    8'h18
`define OSCCC_RST_RANGE           2'h0

// ==========================================================================
// Field positions and writable masks
`define OSCCC_CC_FAST_EN          4
`define OSCCC_CC_EXT_SEL          2
`define OSCCC_CC_WMASK            8'h14
`define OSCCC_LT_BIAS_OFF         6
`define OSCCC_LT_RATE_SEL         5
`define OSCCC_LT_WMASK            8'h6F
`define OSCCC_SS_BOOT_REP         7
`define OSCCC_SS_RANGE_HI         4
`define OSCCC_SS_RANGE_LO         3
`define OSCCC_SS_RAM_RED          0
`define OSCCC_AUX_DBL_DIS         0

// ==========================================================================
// Range codes and interrupt events
`define OSCCC_RANGE_12MHZ         2'h0
`define OSCCC_RANGE_6MHZ          2'h1
`define OSCCC_RANGE_24MHZ         2'h2
`define OSCCC_RANGE_RESERVED_BIT          2'h3
`define OSCCC_EV_RANGE_CHG        0
`define OSCCC_EV_RANGE_RESERVED_BIT       1
`define OSCCC_EV_BOOT_REP         2
`define OSCCC_EV_EXT_CHG          3
`define OSCCC_NUM_EV              4

// ==========================================================================
// Bus answers
`define OSCCC_RESP_OKAY           2'h0
`define OSCCC_RESP_SLVERR         2'h2

`endif

// ==== logic/osccc_pkg.sv ====
// Types of the oscillator clock control: bus carriers, register select and module state.
// Assumes the constants header of the block is found on the include path.
`default_nettype none
`include "osccc_cfg.svh"

package osccc_pkg;

	// ======================================================================
	// AXI4-Lite carriers
	typedef struct packed {
		logic [11:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [11:0] araddr;
		logic        arvalid;
		logic        rready;
	} osccc_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} osccc_axi_rsp_s;

	// ======================================================================
	// Register select
	typedef enum logic [2:0] {
		OSCCC_R_NONE  = 3'h0,
		OSCCC_R_CC    = 3'h1,
		OSCCC_R_MT    = 3'h2,
		OSCCC_R_LT    = 3'h3,
		OSCCC_R_SS    = 3'h4,
		OSCCC_R_IST   = 3'h5,
		OSCCC_R_IMSK  = 3'h6,
		OSCCC_R_AUX   = 3'h7
	} osccc_reg_e;

	// ======================================================================
	// Whole module state
	typedef struct packed {
		osccc_axi_rsp_s              rsp;
		logic                        aw_have;
		logic                        w_have;
		logic [11:0]                 aw_addr;
		logic [31:0]                 w_data;
		logic [3:0]                  w_strb;
		logic [7:0]                  clk_cfg;
		logic [7:0]                  main_trim;
		logic [7:0]                  low_trim;
		logic [1:0]                  range;
		logic                        ram_reduce;
		logic                        boot_flag;
		logic [1:0]                  boot_cnt;
		logic [`OSCCC_NUM_EV-1:0]    irq_status;
		logic [`OSCCC_NUM_EV-1:0]    irq_mask;
		logic                        dbl_dis;
		logic                        bias_en;
		logic                        ext_sync;
		logic                        irq;
	} osccc_state_s;

endpackage : osccc_pkg
`default_nettype wire

// ==== logic/osccc_top.sv ====
// Register front end of the on-chip clock sources: main oscillator range and trim,
// external clock select, fast clock enable, low-speed oscillator settings and boot status.
// Assumes an AXI4-Lite master on the same clock and analogue oscillators that obey the outputs.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "osccc_cfg.svh"

// Functional notes
// - Range code 00 gives 12 MHz, 01 gives 6 MHz, 10 gives 24 MHz.
// - A range write takes effect at once, with no settling delay.
// - Main oscillator trim is eight bits, bit 0 least significant.
// - Boot loads the factory main oscillator trim before user code.
// - Without external select the main oscillator drives the system clock.
// - External select makes the external input the clock source; all syncs follow.
// - Fast clock enable bit turns the 48 MHz clock on or off.
// - Boot repeat flag is set when the boot routine ran more than once.
// - RAM init reduce zero clears full RAM after watchdog reset; one clears minimum.
// - Low-speed rate bit set gives 1 kHz, clear gives 32 kHz.
// - Bias-off bit high removes the bias when the low-speed oscillator is down.
// - Low-speed trim is loaded from the factory value at boot.
// - Low-speed oscillator clocks sleep and watchdog and feeds digital blocks.
// - The clock doubler has a disable control to save power.
module osccc_top (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rstn,
	input  wire osccc_pkg::osccc_axi_req_s i_axi,
	output var  osccc_pkg::osccc_axi_rsp_s o_axi,
	input  wire logic                  i_boot_load,
	input  wire logic                  i_boot_pass,
	input  wire logic [7:0]            i_main_trim_factory,
	input  wire logic [3:0]            i_low_trim_factory,
	input  wire logic                  i_low_osc_powerdown,
	output logic [1:0]                 o_range_select,
	output logic [7:0]                 o_main_osc_trim,
	output logic                       o_system_clock_src_ext,
	output logic                       o_low_osc_sync_ext,
	output logic                       o_fast_clock_enable,
	output logic                       o_doubler_enable,
	output logic                       o_low_osc_rate_select,
	output logic                       o_bias_off_on_powerdown,
	output logic                       o_low_osc_bias_en,
	output logic [3:0]                 o_low_osc_trim,
	output logic                       o_low_osc_enable,
	output logic                       o_ram_init_reduce,
	output logic                       o_ram_clear_full,
	output logic                       o_boot_repeat_flag,
	output logic                       o_irq
);
	import osccc_pkg::*;

	osccc_state_s st_ff;
	osccc_state_s nxt_st;

	logic                     aw_fire;
	logic                     w_fire;
	logic                     ar_fire;
	logic                     wr_go;
	logic [11:0]              wr_addr;
	logic [31:0]              wr_data;
	logic                     wr_lane0;
	osccc_reg_e               wr_sel;
	osccc_reg_e               rd_sel;
	logic [7:0]               rd_byte;
	logic [1:0]               new_range;
	logic [`OSCCC_NUM_EV-1:0] ev;
	logic [`OSCCC_NUM_EV-1:0] ist_clr;

	// ======================================================================
	// Address decode shared by reads and writes.
	function automatic osccc_reg_e reg_decode(input logic [11:0] addr);
		logic [9:0] idx;
		idx = addr[11:2];
		unique case (idx)
			`OSCCC_IDX_CLOCK_CONFIG:  reg_decode = OSCCC_R_CC;
			`OSCCC_IDX_MAIN_OSC_TRIM: reg_decode = OSCCC_R_MT;
			`OSCCC_IDX_LOW_OSC_TRIM:  reg_decode = OSCCC_R_LT;
			`OSCCC_IDX_SYS_STATUS:    reg_decode = OSCCC_R_SS;
			`OSCCC_IDX_IRQ_STATUS:    reg_decode = OSCCC_R_IST;
			`OSCCC_IDX_IRQ_MASK:      reg_decode = OSCCC_R_IMSK;
			`OSCCC_IDX_AUX_CTRL:      reg_decode = OSCCC_R_AUX;
			default:                  reg_decode = OSCCC_R_NONE;
		endcase
	endfunction : reg_decode

	// ======================================================================
	// Next state.
	always_comb begin
		nxt_st   = st_ff;
		aw_fire  = i_axi.awvalid & st_ff.rsp.awready;
		w_fire   = i_axi.wvalid & st_ff.rsp.wready;
		ar_fire  = i_axi.arvalid & st_ff.rsp.arready;
		wr_addr  = st_ff.aw_have ? st_ff.aw_addr : i_axi.awaddr;
		wr_data  = st_ff.w_have ? st_ff.w_data : i_axi.wdata;
		wr_lane0 = st_ff.w_have ? st_ff.w_strb[0] : i_axi.wstrb[0];
		wr_go    = (st_ff.aw_have | aw_fire) & (st_ff.w_have | w_fire) & ~st_ff.rsp.bvalid;
		wr_sel   = reg_decode(wr_addr);
		rd_sel   = reg_decode(i_axi.araddr);
		new_range = wr_data[`OSCCC_SS_RANGE_HI:`OSCCC_SS_RANGE_LO];
		ev       = '0;
		ist_clr  = '0;

		// Write address and data are taken in either order and held.
		if (aw_fire) begin
			nxt_st.aw_have     = 1'b1;
			nxt_st.aw_addr     = i_axi.awaddr;
			nxt_st.rsp.awready = 1'b0;
		end
		if (w_fire) begin
			nxt_st.w_have     = 1'b1;
			nxt_st.w_data     = i_axi.wdata;
			nxt_st.w_strb     = i_axi.wstrb;
			nxt_st.rsp.wready = 1'b0;
		end
		if (st_ff.rsp.bvalid & i_axi.bready) begin
			nxt_st.rsp.bvalid  = 1'b0;
			nxt_st.rsp.awready = 1'b1;
			nxt_st.rsp.wready  = 1'b1;
		end

		if (wr_go) begin
			nxt_st.aw_have     = 1'b0;
			nxt_st.w_have      = 1'b0;
			nxt_st.rsp.awready = 1'b0;
			nxt_st.rsp.wready  = 1'b0;
			nxt_st.rsp.bvalid  = 1'b1;
			nxt_st.rsp.bresp   = (wr_sel == OSCCC_R_NONE) ? `OSCCC_RESP_SLVERR : `OSCCC_RESP_OKAY;
			if (wr_lane0) begin
				unique case (wr_sel)
					OSCCC_R_CC: begin
						// Reserved bit 1 and other unused bits stay zero.
						nxt_st.clk_cfg = wr_data[7:0] & `OSCCC_CC_WMASK;
						if (wr_data[`OSCCC_CC_EXT_SEL] != st_ff.clk_cfg[`OSCCC_CC_EXT_SEL]) begin
							ev[`OSCCC_EV_EXT_CHG] = 1'b1;
						end
					end
					OSCCC_R_MT: begin
						nxt_st.main_trim = wr_data[7:0];
					end
					OSCCC_R_LT: begin
						nxt_st.low_trim = (st_ff.low_trim & ~`OSCCC_LT_WMASK)
							| (wr_data[7:0] & `OSCCC_LT_WMASK);
					end
					OSCCC_R_SS: begin
						nxt_st.ram_reduce = wr_data[`OSCCC_SS_RAM_RED];
						if (new_range == `OSCCC_RANGE_RESERVED_BIT) begin
							ev[`OSCCC_EV_RANGE_RESERVED_BIT] = 1'b1;
						end else begin
							nxt_st.range = new_range;
							ev[`OSCCC_EV_RANGE_CHG] = (new_range != st_ff.range);
						end
					end
					OSCCC_R_IST: begin
						ist_clr = wr_data[`OSCCC_NUM_EV-1:0];
					end
					OSCCC_R_IMSK: begin
						nxt_st.irq_mask = wr_data[`OSCCC_NUM_EV-1:0];
					end
					OSCCC_R_AUX: begin
						nxt_st.dbl_dis = wr_data[`OSCCC_AUX_DBL_DIS];
					end
					OSCCC_R_NONE: begin
						nxt_st.dbl_dis = st_ff.dbl_dis;
					end
				endcase
			end
		end

		// Read answers one cycle after the address is taken.
		unique case (rd_sel)
			OSCCC_R_CC:   rd_byte = st_ff.clk_cfg;
			OSCCC_R_MT:   rd_byte = st_ff.main_trim;
			OSCCC_R_LT:   rd_byte = st_ff.low_trim;
			OSCCC_R_SS:   rd_byte = {st_ff.boot_flag, 2'h0, st_ff.range, 2'h0, st_ff.ram_reduce};
			OSCCC_R_IST:  rd_byte = {4'h0, st_ff.irq_status};
			OSCCC_R_IMSK: rd_byte = {4'h0, st_ff.irq_mask};
			OSCCC_R_AUX:  rd_byte = {7'h00, st_ff.dbl_dis};
			OSCCC_R_NONE: rd_byte = 8'h00;
		endcase
		if (ar_fire) begin
			nxt_st.rsp.arready = 1'b0;
			nxt_st.rsp.rvalid  = 1'b1;
			nxt_st.rsp.rdata   = {24'h000000, rd_byte};
			nxt_st.rsp.rresp   = (rd_sel == OSCCC_R_NONE) ? `OSCCC_RESP_SLVERR : `OSCCC_RESP_OKAY;
		end
		if (st_ff.rsp.rvalid & i_axi.rready) begin
			nxt_st.rsp.rvalid  = 1'b0;
			nxt_st.rsp.arready = 1'b1;
		end

		// Boot loads factory trims; boot writes win over a bus write in the same cycle.
		if (i_boot_load) begin
			nxt_st.main_trim     = i_main_trim_factory;
			nxt_st.low_trim[3:0] = i_low_trim_factory;
		end
		if (i_boot_pass) begin
			if (st_ff.boot_cnt != 2'h3) begin
				nxt_st.boot_cnt = st_ff.boot_cnt + 2'h1;
			end
			if (st_ff.boot_cnt != 2'h0) begin
				nxt_st.boot_flag = 1'b1;
				ev[`OSCCC_EV_BOOT_REP] = ~st_ff.boot_flag;
			end
		end

		// A new event wins over a clear in the same cycle.
		nxt_st.irq_status = (st_ff.irq_status & ~ist_clr) | ev;
		nxt_st.irq        = |(nxt_st.irq_status & nxt_st.irq_mask);

		nxt_st.bias_en  = ~(i_low_osc_powerdown & nxt_st.low_trim[`OSCCC_LT_BIAS_OFF]);
		nxt_st.ext_sync = nxt_st.clk_cfg[`OSCCC_CC_EXT_SEL];
	end

	// ======================================================================
	// State register.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			st_ff             <= '0;
			st_ff.rsp.awready <= 1'b1;
			st_ff.rsp.wready  <= 1'b1;
			st_ff.rsp.arready <= 1'b1;
			st_ff.clk_cfg     <= `OSCCC_RST_CLOCK_CONFIG;
			st_ff.main_trim   <= `OSCCC_RST_MAIN_OSC_TRIM;
			st_ff.low_trim    <= `OSCCC_RST_LOW_OSC_TRIM;
			st_ff.range       <= `OSCCC_RST_RANGE;
			st_ff.bias_en     <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ======================================================================
	// Outputs, all taken from the state register.
	assign o_axi                   = st_ff.rsp;
	assign o_range_select          = st_ff.range;
	assign o_main_osc_trim         = st_ff.main_trim;
	assign o_system_clock_src_ext        = st_ff.clk_cfg[`OSCCC_CC_EXT_SEL];
	assign o_low_osc_sync_ext      = st_ff.ext_sync;
	assign o_fast_clock_enable     = st_ff.clk_cfg[`OSCCC_CC_FAST_EN];
	assign o_doubler_enable        = ~st_ff.dbl_dis;
	assign o_low_osc_rate_select   = st_ff.low_trim[`OSCCC_LT_RATE_SEL];
	assign o_bias_off_on_powerdown = st_ff.low_trim[`OSCCC_LT_BIAS_OFF];
	assign o_low_osc_bias_en       = st_ff.bias_en;
	assign o_low_osc_trim          = st_ff.low_trim[3:0];
	// The low-speed oscillator stays on for sleep, watchdog and the digital blocks unless powered down with the bias-off bit set.
	assign o_low_osc_enable        = st_ff.bias_en | ~st_ff.low_trim[`OSCCC_LT_BIAS_OFF];
	assign o_ram_init_reduce       = st_ff.ram_reduce;
	assign o_ram_clear_full        = ~st_ff.ram_reduce;
	assign o_boot_repeat_flag      = st_ff.boot_flag;
	assign o_irq                   = st_ff.irq;

	// ======================================================================
	// Assertions.
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	logic ss_wr;
	logic ss_legal_wr;
	assign ss_wr       = wr_go & wr_lane0 & (wr_sel == OSCCC_R_SS) & ~i_boot_load;
	assign ss_legal_wr = ss_wr & (new_range != `OSCCC_RANGE_RESERVED_BIT);

	property p_range_code;
		ss_legal_wr |=> o_range_select == $past(new_range);
	endproperty
	a_range_code: assert property (p_range_code) else $error("range code not applied");

	property p_range_cause;
		$changed(o_range_select) |-> $past(ss_legal_wr);
	endproperty
	a_range_cause: assert property (p_range_cause) else $error("range moved without write");

	property p_main_trim;
		wr_go & wr_lane0 & (wr_sel == OSCCC_R_MT) & ~i_boot_load
			|=> o_main_osc_trim == $past(wr_data[7:0]);
	endproperty
	a_main_trim: assert property (p_main_trim) else $error("main trim write lost");

	property p_boot_main;
		i_boot_load |=> o_main_osc_trim == $past(i_main_trim_factory);
	endproperty
	a_boot_main: assert property (p_boot_main) else $error("factory main trim not loaded");

	property p_ext_sel;
		wr_go & wr_lane0 & (wr_sel == OSCCC_R_CC)
			|=> o_system_clock_src_ext == $past(wr_data[`OSCCC_CC_EXT_SEL]) ##1 o_low_osc_sync_ext == o_system_clock_src_ext;
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("external select not followed");

	property p_fast_en;
		wr_go & wr_lane0 & (wr_sel == OSCCC_R_CC)
			|=> o_fast_clock_enable == $past(wr_data[`OSCCC_CC_FAST_EN]);
	endproperty
	a_fast_en: assert property (p_fast_en) else $error("fast clock enable not followed");

	property p_boot_rep;
		i_boot_pass && st_ff.boot_cnt != 2'h0 |=> o_boot_repeat_flag
			&& ($past(o_boot_repeat_flag) || st_ff.irq_status[`OSCCC_EV_BOOT_REP]);
	endproperty
	a_boot_rep: assert property (p_boot_rep) else $error("boot repeat flag not set");

	property p_boot_once;
		$rose(o_boot_repeat_flag) |-> $past(st_ff.boot_cnt) != 2'h0 && $past(i_boot_pass);
	endproperty
	a_boot_once: assert property (p_boot_once) else $error("boot repeat flag set early");

	property p_ram_clear;
		ss_wr |=> o_ram_clear_full == !$past(wr_data[`OSCCC_SS_RAM_RED]);
	endproperty
	a_ram_clear: assert property (p_ram_clear) else $error("RAM clear amount wrong");

	property p_bias;
		i_low_osc_powerdown && o_bias_off_on_powerdown ##1 i_low_osc_powerdown && o_bias_off_on_powerdown
			|-> !o_low_osc_bias_en;
	endproperty
	a_bias: assert property (p_bias) else $error("bias kept while powered down");

	property p_boot_low;
		i_boot_load |=> o_low_osc_trim == $past(i_low_trim_factory);
	endproperty
	a_boot_low: assert property (p_boot_low) else $error("factory low trim not loaded");

	property p_reserved_bit_range;
		ss_wr && new_range == `OSCCC_RANGE_RESERVED_BIT |=> $stable(o_range_select)
			&& st_ff.irq_status[`OSCCC_EV_RANGE_RESERVED_BIT];
	endproperty
	a_reserved_bit_range: assert property (p_reserved_bit_range) else $error("reserved range code applied");

	c_read: cover property (ar_fire ##1 o_axi.rvalid);
	c_write: cover property (wr_go ##1 o_axi.bvalid);
	c_irq: cover property ($rose(o_irq));
	c_boot_rep: cover property ($rose(o_boot_repeat_flag));

endmodule : osccc_top
`default_nettype wire

// ==== sim/tb_osccc_top.sv ====
// Self-checking bench of the oscillator clock control: AXI4-Lite tasks and register sequences.
// Assumes the block package and constants header are compiled and found first.
`timescale 1ns/1ps
`default_nettype none
`include "osccc_cfg.svh"

module tb_osccc_top;
	import osccc_pkg::*;

	// ======================================================================
	// Signals
	localparam logic [11:0] A_CC  = 12'h388;
	localparam logic [11:0] A_MT  = 12'h3A0;
	localparam logic [11:0] A_LT  = 12'h3A4;
	localparam logic [11:0] A_SS  = 12'h3F8;
	localparam logic [11:0] A_IST = 12'h3C0;
	localparam logic [11:0] A_IMK = 12'h3C4;
	localparam logic [11:0] A_AUX = 12'h3C8;
	localparam logic [1:0]  OK    = 2'h0;
	localparam logic [1:0]  SLV   = 2'h2;
	logic           clk;
	logic           rstn;
	osccc_axi_req_s axi;
	osccc_axi_rsp_s rsp;
	logic           boot_load;
	logic           boot_pass;
	logic           pdown;
	logic [7:0]     mfac;
	logic [3:0]     lfac;
	logic [1:0]     rng;
	logic [7:0]     mtrim;
	logic           ext;
	logic           sync;
	logic           fast;
	logic           dbl;
	logic           rate;
	logic           boff;
	logic           bias;
	logic [3:0]     ltrim;
	logic           len;
	logic           rred;
	logic           rfull;
	logic           bflag;
	logic           irq;
	int             err_count;
	int             comparisons;

	osccc_top osccc_top_inst (
		.i_clk_sys(clk), .i_rstn(rstn), .i_axi(axi), .o_axi(rsp),
		.i_boot_load(boot_load), .i_boot_pass(boot_pass),
		.i_main_trim_factory(mfac), .i_low_trim_factory(lfac), .i_low_osc_powerdown(pdown),
		.o_range_select(rng), .o_main_osc_trim(mtrim), .o_system_clock_src_ext(ext),
		.o_low_osc_sync_ext(sync), .o_fast_clock_enable(fast), .o_doubler_enable(dbl),
		.o_low_osc_rate_select(rate), .o_bias_off_on_powerdown(boff), .o_low_osc_bias_en(bias),
		.o_low_osc_trim(ltrim), .o_low_osc_enable(len), .o_ram_init_reduce(rred),
		.o_ram_clear_full(rfull), .o_boot_repeat_flag(bflag), .o_irq(irq)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ======================================================================
	// Compare, bus and closing tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t resp got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_rsp

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Address and data are offered together and each is released once taken.
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		axi.awaddr  <= a;
		axi.awvalid <= 1'b1;
		axi.wdata   <= {24'h0, d};
		axi.wstrb   <= 4'hF;
		axi.wvalid  <= 1'b1;
		axi.bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (axi.awvalid && rsp.awready) axi.awvalid <= 1'b0;
			if (axi.wvalid && rsp.wready) axi.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		axi.bready <= 1'b0;
		chk_rsp(rsp.bresp, er);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		axi.araddr  <= a;
		axi.arvalid <= 1'b1;
		axi.rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (axi.arvalid && rsp.arready) axi.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		axi.rready <= 1'b0;
		chk(rsp.rdata, e);
		chk_rsp(rsp.rresp, er);
	endtask : rd

	task automatic results();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	initial begin
		#100000;
		err_count++;
		results();
	end

	// ======================================================================
	// Test sequence
	initial begin
		err_count = 0;
		comparisons = 0;
		axi = '0;
		rstn = 1'b0;
		boot_load = 1'b0;
		boot_pass = 1'b0;
		pdown = 1'b0;
		mfac = 8'h5A;
		lfac = 4'h3;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(A_CC, 32'h00, OK);
		rd(A_LT, 32'h18, OK);
		rd(A_SS, 32'h00, OK);
		chk(32'(dbl), 32'h1);
		@(posedge clk);
		boot_load <= 1'b1;
		boot_pass <= 1'b1;
		@(posedge clk);
		boot_load <= 1'b0;
		boot_pass <= 1'b0;
		tick(1);
		chk(32'(mtrim), 32'h5A);
		chk(32'(ltrim), 32'h3);
		chk(32'(bflag), 32'h0);
		@(posedge clk);
		boot_pass <= 1'b1;
		@(posedge clk);
		boot_pass <= 1'b0;
		tick(1);
		chk(32'(bflag), 32'h1);
		wr(A_SS, 8'h00, OK);
		rd(A_SS, 32'h80, OK);
		// Trim is written while the lower of the two ranges is in force.
		for (int i = 0; i < 3; i++) begin
			if (i != 1) wr(A_MT, 8'h81 + 8'(i), OK);
			wr(A_SS, {3'h0, 2'(2 - i), 3'h0}, OK);
			chk(32'(rng), 32'(2 - i));
			if (i == 1) wr(A_MT, 8'h81 + 8'(i), OK);
			chk(32'(mtrim), 32'h81 + i);
			rd(A_SS, 32'h80 | ((2 - i) << 3), OK);
		end
		rd(A_MT, 32'h83, OK);
		wr(A_SS, 8'h19, OK);
		chk(32'(rng), 32'h0);
		chk(32'({rred, rfull}), 32'h2);
		rd(A_SS, 32'h81, OK);
		wr(A_CC, 8'h14, OK);
		chk(32'({fast, ext}), 32'h3);
		tick(1);
		chk(32'(sync), 32'h1);
		rd(A_CC, 32'h14, OK);
		wr(A_CC, 8'h00, OK);
		chk(32'({fast, ext}), 32'h0);
		wr(A_LT, 8'h6C, OK);
		chk(32'({rate, boff, ltrim}), 32'h3C);
		rd(A_LT, 32'h7C, OK);
		@(posedge clk);
		pdown <= 1'b1;
		tick(2);
		chk(32'({bias, len}), 32'h0);
		wr(A_LT, 8'h0C, OK);
		tick(2);
		chk(32'({rate, bias, len}), 32'h3);
		@(posedge clk);
		pdown <= 1'b0;
		wr(A_AUX, 8'h01, OK);
		chk(32'(dbl), 32'h0);
		wr(A_AUX, 8'h00, OK);
		chk(32'(dbl), 32'h1);
		rd(A_IST, 32'h0F, OK);
		wr(A_IST, 8'h0F, OK);
		wr(A_IMK, 8'h01, OK);
		tick(2);
		chk(32'(irq), 32'h0);
		wr(A_SS, 8'h08, OK);
		tick(2);
		chk(32'(irq), 32'h1);
		rd(A_IST, 32'h01, OK);
		wr(A_IST, 8'h01, OK);
		tick(2);
		chk(32'(irq), 32'h0);
		wr(A_SS, 8'h18, OK);
		tick(2);
		chk(32'({irq, rng}), 32'h1);
		rd(A_IST, 32'h02, OK);
		wr(12'h004, 8'hFF, SLV);
		rd(12'h004, 32'h0, SLV);
		results();
	end

endmodule : tb_osccc_top
`default_nettype wire
